// ---- core/irp_pkg.sv ----
`default_nettype none
package irp_pkg;
  // register bus shape
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int DIV_MAX_W = 10;
  localparam int TEST_DIV_W = 6;
  localparam int FB_DIV_W = 10;

  // register offsets
  localparam logic [ADDR_W-1:0] RX_CTRL_OFS = 10'h01a;
  localparam logic [ADDR_W-1:0] FB_PATH_OFS = 10'h01b;

  // reset values: every documented default is a cleared bit
  localparam logic [DATA_W-1:0] RX_CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] FB_PATH_RST = 8'h00;

  // input_receiver_control fields
  localparam int RC_TEST_REF_EN = 7;
  localparam int RC_SEC_DIFF = 6;
  localparam int RC_PRI_DIFF = 5;
  localparam int RC_SEC_EN = 4;
  localparam int RC_PRI_EN = 3;
  localparam int RC_PD_CTRL = 2;
  localparam int RC_OSC_SE_NEG = 1;
  localparam int RC_OSC_DIFF = 0;

  // feedback_path_and_single_ended_select fields
  localparam int FP_TEST_BYP = 7;
  localparam int FP_FB_BYP = 6;
  localparam int FP_ZD_INTERNAL = 5;
  localparam int FP_FB_FROM_OSC = 4;
  localparam int FP_ZD_SE_SEL = 3;
  localparam int FP_ZD_DIFF = 2;
  localparam int FP_SEC_SE_SEL = 1;
  localparam int FP_PRI_SE_SEL = 0;

  // divide ratio forced by a bypass, and the largest word that still means it
  localparam logic [DIV_MAX_W-1:0] DIV_ONE = 10'h001;

  // where the input loop takes its feedback from
  typedef enum logic [2:0] {
    IRP_FB_OSC    = 3'h1,
    IRP_FB_ZD_INT = 3'h2,
    IRP_FB_ZD_EXT = 3'h4
  } irp_fb_src_t;
endpackage : irp_pkg
`default_nettype wire

// ---- core/irp_rx_mode.sv ----
`default_nettype none
// one receiver: power, differential or one of two single-ended pins
module irp_rx_mode (
  input wire logic rx_on,
  input wire logic diff_sel,
  input wire logic se_alt,
  output logic diff_en,
  output logic pos_en,
  output logic neg_en
);
  // single-ended pin choice only matters while the receiver is not differential
  assign diff_en = rx_on & diff_sel;
  assign pos_en = rx_on & ~diff_sel & ~se_alt;
  assign neg_en = rx_on & ~diff_sel & se_alt;
endmodule : irp_rx_mode
`default_nettype wire

// ---- core/irp_input_rx_cfg.sv ----
`default_nettype none
module irp_input_rx_cfg #(
  parameter int ADDR_W = irp_pkg::ADDR_W,
  parameter int TEST_DIV_W = irp_pkg::TEST_DIV_W,
  parameter int FB_DIV_W = irp_pkg::FB_DIV_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // register access port, same clock as the control port logic
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [irp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [irp_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_unmapped,
  // programmed divider words from the neighbouring divider registers
  input wire logic [TEST_DIV_W-1:0] test_div_word,
  input wire logic [FB_DIV_W-1:0] fb_div_word,
  // receiver controls
  output logic test_reference_rx_en,
  output logic primary_reference_diff_en,
  output logic primary_reference_pos_en,
  output logic primary_reference_neg_en,
  output logic secondary_reference_diff_en,
  output logic secondary_reference_pos_en,
  output logic secondary_reference_neg_en,
  output logic oscillator_input_diff_en,
  output logic oscillator_input_pos_en,
  output logic oscillator_input_neg_en,
  output logic zero_delay_input_diff_en,
  output logic zero_delay_input_pos_en,
  output logic zero_delay_input_neg_en,
  // divider and feedback path controls
  output logic test_div_bypass,
  output logic fb_div_bypass,
  output logic [irp_pkg::DIV_MAX_W-1:0] test_div_ratio,
  output logic [irp_pkg::DIV_MAX_W-1:0] fb_div_ratio,
  output logic [2:0] input_loop_fb_src
);

  // refuse shapes the decode cannot serve
  if (ADDR_W < 5 || TEST_DIV_W < 1 || TEST_DIV_W > irp_pkg::DIV_MAX_W ||
      FB_DIV_W < 1 || FB_DIV_W > irp_pkg::DIV_MAX_W) begin : g_bad_param
    $error("irp_input_rx_cfg: unsupported parameter values");
  end

  // local copy of the ratio width so size casts need no scoped name
  localparam int DMW = irp_pkg::DIV_MAX_W;

  // a word of 0 or 1 already means divide by one, so bypass folds into it
  // comparing against one keeps a zero word from ever meaning divide by zero
  function automatic logic [irp_pkg::DIV_MAX_W-1:0] eff_div(
    input logic bypass,
    input logic [irp_pkg::DIV_MAX_W-1:0] word
  );
    if (bypass || word <= irp_pkg::DIV_ONE) begin
      return irp_pkg::DIV_ONE;
    end
    return word;
  endfunction : eff_div

  // stored configuration
  logic [irp_pkg::DATA_W-1:0] rx_ctrl_reg;
  logic [irp_pkg::DATA_W-1:0] fb_path_reg;
  logic [irp_pkg::DATA_W-1:0] rx_ctrl_next;
  logic [irp_pkg::DATA_W-1:0] fb_path_next;

  // read side
  logic [irp_pkg::DATA_W-1:0] rdata_reg;
  logic [irp_pkg::DATA_W-1:0] rdata_next;
  logic rvalid_reg;
  logic unmapped_reg;

  // decoded controls, registered so every output leaves a flip-flop
  logic test_rx_reg;
  logic pri_diff_reg;
  logic pri_pos_reg;
  logic pri_neg_reg;
  logic sec_diff_reg;
  logic sec_pos_reg;
  logic sec_neg_reg;
  logic osc_diff_reg;
  logic osc_pos_reg;
  logic osc_neg_reg;
  logic zd_diff_reg;
  logic zd_pos_reg;
  logic zd_neg_reg;
  logic test_byp_reg;
  logic fb_byp_reg;
  logic [irp_pkg::DIV_MAX_W-1:0] test_ratio_reg;
  logic [irp_pkg::DIV_MAX_W-1:0] fb_ratio_reg;
  irp_pkg::irp_fb_src_t fb_src_reg;
  irp_pkg::irp_fb_src_t fb_src_next;

  // address decode
  // anything outside the two registers is flagged, never aliased onto them
  wire sel_rx_ctrl = (reg_addr == irp_pkg::RX_CTRL_OFS);
  wire sel_fb_path = (reg_addr == irp_pkg::FB_PATH_OFS);
  wire sel_any = sel_rx_ctrl | sel_fb_path;
  wire wr_rx_ctrl = reg_wr & sel_rx_ctrl;
  wire wr_fb_path = reg_wr & sel_fb_path;

  // plain storage, whole byte written at once
  // no byte lanes: a write always replaces all eight control bits
  assign rx_ctrl_next = wr_rx_ctrl ? reg_wdata : rx_ctrl_reg;
  assign fb_path_next = wr_fb_path ? reg_wdata : fb_path_reg;

  // read mux; an unmapped address reads zero
  // the answer is registered so read data never hangs on address settling
  assign rdata_next = sel_rx_ctrl ? rx_ctrl_reg :
                      sel_fb_path ? fb_path_reg : 8'h00;

  // receiver control field taps
  wire test_en_bit = rx_ctrl_reg[irp_pkg::RC_TEST_REF_EN];
  wire sec_diff_bit = rx_ctrl_reg[irp_pkg::RC_SEC_DIFF];
  wire pri_diff_bit = rx_ctrl_reg[irp_pkg::RC_PRI_DIFF];
  wire sec_en_bit = rx_ctrl_reg[irp_pkg::RC_SEC_EN];
  wire pri_en_bit = rx_ctrl_reg[irp_pkg::RC_PRI_EN];
  wire pd_ctrl_bit = rx_ctrl_reg[irp_pkg::RC_PD_CTRL];
  wire osc_neg_bit = rx_ctrl_reg[irp_pkg::RC_OSC_SE_NEG];
  wire osc_diff_bit = rx_ctrl_reg[irp_pkg::RC_OSC_DIFF];

  // feedback path field taps
  wire test_byp_bit = fb_path_reg[irp_pkg::FP_TEST_BYP];
  wire fb_byp_bit = fb_path_reg[irp_pkg::FP_FB_BYP];
  wire zd_int_bit = fb_path_reg[irp_pkg::FP_ZD_INTERNAL];
  wire fb_osc_bit = fb_path_reg[irp_pkg::FP_FB_FROM_OSC];
  wire zd_sel_bit = fb_path_reg[irp_pkg::FP_ZD_SE_SEL];
  wire zd_diff_bit = fb_path_reg[irp_pkg::FP_ZD_DIFF];
  wire sec_sel_bit = fb_path_reg[irp_pkg::FP_SEC_SE_SEL];
  wire pri_sel_bit = fb_path_reg[irp_pkg::FP_PRI_SE_SEL];

  // with power-down control off both references stay powered
  // the individual enables are don't-care until power-down control is set
  wire pri_on = ~pd_ctrl_bit | pri_en_bit;
  wire sec_on = ~pd_ctrl_bit | sec_en_bit;

  // zero-delay mode only counts when feedback is not from the oscillator;
  // the zero-delay receiver is also left off then, since nothing uses it
  wire zd_active = ~fb_osc_bit;
  wire zd_internal = zd_active & zd_int_bit;
  wire zd_rx_on = zd_active & ~zd_int_bit;

  // feedback source selection, one-hot
  // oscillator feedback wins, so bit 5 only matters with bit 4 clear
  assign fb_src_next = fb_osc_bit ? irp_pkg::IRP_FB_OSC :
                       zd_internal ? irp_pkg::IRP_FB_ZD_INT :
                       irp_pkg::IRP_FB_ZD_EXT;

  // per-receiver pin decode
  wire pri_diff_w;
  wire pri_pos_w;
  wire pri_neg_w;
  wire sec_diff_w;
  wire sec_pos_w;
  wire sec_neg_w;
  wire osc_diff_w;
  wire osc_pos_w;
  wire osc_neg_w;
  wire zd_diff_w;
  wire zd_pos_w;
  wire zd_neg_w;

  // primary reference: diff from receiver control, pin from second register
  irp_rx_mode u_pri_rx (
    .rx_on(pri_on),
    .diff_sel(pri_diff_bit),
    .se_alt(pri_sel_bit),
    .diff_en(pri_diff_w),
    .pos_en(pri_pos_w),
    .neg_en(pri_neg_w)
  );

  // secondary reference
  irp_rx_mode u_sec_rx (
    .rx_on(sec_on),
    .diff_sel(sec_diff_bit),
    .se_alt(sec_sel_bit),
    .diff_en(sec_diff_w),
    .pos_en(sec_pos_w),
    .neg_en(sec_neg_w)
  );

  // oscillator input has no power-down of its own
  // it carries the local feedback, so switching it off would open the loop
  irp_rx_mode u_osc_rx (
    .rx_on(1'b1),
    .diff_sel(osc_diff_bit),
    .se_alt(osc_neg_bit),
    .diff_en(osc_diff_w),
    .pos_en(osc_pos_w),
    .neg_en(osc_neg_w)
  );

  // zero-delay input, powered only for external zero-delay
  irp_rx_mode u_zd_rx (
    .rx_on(zd_rx_on),
    .diff_sel(zd_diff_bit),
    .se_alt(zd_sel_bit),
    .diff_en(zd_diff_w),
    .pos_en(zd_pos_w),
    .neg_en(zd_neg_w)
  );

  // effective divide ratios
  wire [DMW-1:0] test_word_ext =
    DMW'(test_div_word);
  wire [DMW-1:0] fb_word_ext =
    DMW'(fb_div_word);
  wire [irp_pkg::DIV_MAX_W-1:0] test_ratio_w = eff_div(test_byp_bit, test_word_ext);
  wire [irp_pkg::DIV_MAX_W-1:0] fb_ratio_w = eff_div(fb_byp_bit, fb_word_ext);

  // configuration storage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_ctrl_reg <= irp_pkg::RX_CTRL_RST;
      fb_path_reg <= irp_pkg::FB_PATH_RST;
    end else if (ce) begin
      rx_ctrl_reg <= rx_ctrl_next;
      fb_path_reg <= fb_path_next;
    end
  end

  // read answer one cycle after the request; unmapped flag rides with it
  // with ce low a pending answer is frozen rather than dropped
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      unmapped_reg <= 1'b0;
    end else if (ce) begin
      rdata_reg <= reg_rd ? rdata_next : rdata_reg;
      rvalid_reg <= reg_rd;
      unmapped_reg <= (reg_rd | reg_wr) & ~sel_any;
    end
  end

  // reference and test receivers
  // reset shows the decode of the all-zero word, so no receiver blinks off
  always_ff @(posedge clk) begin
    if (!nrst) begin
      test_rx_reg <= 1'b0;
      pri_diff_reg <= 1'b0;
      pri_pos_reg <= 1'b1;
      pri_neg_reg <= 1'b0;
      sec_diff_reg <= 1'b0;
      sec_pos_reg <= 1'b1;
      sec_neg_reg <= 1'b0;
    end else if (ce) begin
      test_rx_reg <= test_en_bit;
      pri_diff_reg <= pri_diff_w;
      pri_pos_reg <= pri_pos_w;
      pri_neg_reg <= pri_neg_w;
      sec_diff_reg <= sec_diff_w;
      sec_pos_reg <= sec_pos_w;
      sec_neg_reg <= sec_neg_w;
    end
  end

  // oscillator and zero-delay receivers
  // reset values match external zero-delay with single-ended positive pins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      osc_diff_reg <= 1'b0;
      osc_pos_reg <= 1'b1;
      osc_neg_reg <= 1'b0;
      zd_diff_reg <= 1'b0;
      zd_pos_reg <= 1'b1;
      zd_neg_reg <= 1'b0;
    end else if (ce) begin
      osc_diff_reg <= osc_diff_w;
      osc_pos_reg <= osc_pos_w;
      osc_neg_reg <= osc_neg_w;
      zd_diff_reg <= zd_diff_w;
      zd_pos_reg <= zd_pos_w;
      zd_neg_reg <= zd_neg_w;
    end
  end

  // dividers and feedback path; reset mirrors the reset word's decode, but both ratios reset to DIV_ONE whatever the divider words
  always_ff @(posedge clk) begin
    if (!nrst) begin
      test_byp_reg <= 1'b0;
      fb_byp_reg <= 1'b0;
      test_ratio_reg <= irp_pkg::DIV_ONE;
      fb_ratio_reg <= irp_pkg::DIV_ONE;
      fb_src_reg <= irp_pkg::IRP_FB_ZD_EXT;
    end else if (ce) begin
      test_byp_reg <= test_byp_bit;
      fb_byp_reg <= fb_byp_bit;
      test_ratio_reg <= test_ratio_w;
      fb_ratio_reg <= fb_ratio_w;
      fb_src_reg <= fb_src_next;
    end
  end

  // every output straight from its flip-flop
  // nothing is decoded after the flops, so no glitch reaches the receivers
  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign reg_unmapped = unmapped_reg;
  assign test_reference_rx_en = test_rx_reg;
  assign primary_reference_diff_en = pri_diff_reg;
  assign primary_reference_pos_en = pri_pos_reg;
  assign primary_reference_neg_en = pri_neg_reg;
  assign secondary_reference_diff_en = sec_diff_reg;
  assign secondary_reference_pos_en = sec_pos_reg;
  assign secondary_reference_neg_en = sec_neg_reg;
  assign oscillator_input_diff_en = osc_diff_reg;
  assign oscillator_input_pos_en = osc_pos_reg;
  assign oscillator_input_neg_en = osc_neg_reg;
  assign zero_delay_input_diff_en = zd_diff_reg;
  assign zero_delay_input_pos_en = zd_pos_reg;
  assign zero_delay_input_neg_en = zd_neg_reg;
  assign test_div_bypass = test_byp_reg;
  assign fb_div_bypass = fb_byp_reg;
  assign test_div_ratio = test_ratio_reg;
  assign fb_div_ratio = fb_ratio_reg;
  assign input_loop_fb_src = fb_src_reg;

endmodule : irp_input_rx_cfg
`default_nettype wire

// ---- tb/irp_input_rx_cfg_properties.sv ----
`default_nettype none
// watches the register port and decoded controls from outside the block
module irp_input_rx_cfg_properties #(
  parameter int ADDR_W = 10
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_unmapped,
  input wire logic test_div_bypass,
  input wire logic [9:0] test_div_ratio,
  input wire logic oscillator_input_diff_en,
  input wire logic oscillator_input_pos_en,
  input wire logic oscillator_input_neg_en,
  input wire logic zero_delay_input_diff_en,
  input wire logic zero_delay_input_pos_en,
  input wire logic zero_delay_input_neg_en,
  input wire logic [2:0] input_loop_fb_src
);
  timeunit 1ns;
  timeprecision 1ns;
  // address decode and grouped receiver enables
  wire logic rx_hit = reg_addr == irp_pkg::RX_CTRL_OFS;
  wire logic fb_hit = reg_addr == irp_pkg::FB_PATH_OFS;
  wire logic [2:0] osc = {oscillator_input_diff_en, oscillator_input_pos_en,
    oscillator_input_neg_en};
  wire logic [2:0] zd = {zero_delay_input_diff_en, zero_delay_input_pos_en,
    zero_delay_input_neg_en};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // a write lands in the register, then in the output flop one edge later
  sequence s_fb_wr;
    ce && reg_wr && fb_hit ##1 ce;
  endsequence
  sequence s_rx_wr;
    ce && reg_wr && rx_hit ##1 ce;
  endsequence
  property p_rd_valid;
    ce && reg_rd |=> reg_rvalid;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
  property p_no_spurious;
    ce && !reg_rd |=> !reg_rvalid;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("stray read valid");
  property p_unmapped;
    ce && (reg_rd || reg_wr) && !rx_hit && !fb_hit |=>
      reg_unmapped && (!reg_rvalid || reg_rdata == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access wrong");
  property p_bypass;
    s_fb_wr |=> test_div_bypass == $past(reg_wdata[7], 2);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not applied");
  property p_bypass_ratio;
    test_div_bypass |-> test_div_ratio == irp_pkg::DIV_ONE;
  endproperty
  a_bypass_ratio: assert property (p_bypass_ratio) else $error("bypass ratio wrong");
  property p_osc_write;
    s_rx_wr |=> oscillator_input_diff_en == $past(reg_wdata[0], 2);
  endproperty
  a_osc_write: assert property (p_osc_write) else $error("osc mode not applied");
  property p_osc_onehot;
    $onehot(osc);
  endproperty
  a_osc_onehot: assert property (p_osc_onehot) else $error("osc enables wrong");
  property p_zd_src;
    input_loop_fb_src == 3'h4 ? $onehot(zd) : zd == 3'h0;
  endproperty
  a_zd_src: assert property (p_zd_src) else $error("zero delay rx wrong");
  property p_src_onehot;
    $onehot(input_loop_fb_src);
  endproperty
  a_src_onehot: assert property (p_src_onehot) else $error("fb source wrong");
endmodule : irp_input_rx_cfg_properties
bind irp_input_rx_cfg irp_input_rx_cfg_properties #(.ADDR_W(ADDR_W))
  u_irp_input_rx_cfg_properties (.clk, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .reg_rvalid, .reg_unmapped, .test_div_bypass, .test_div_ratio,
  .oscillator_input_diff_en, .oscillator_input_pos_en, .oscillator_input_neg_en,
  .zero_delay_input_diff_en, .zero_delay_input_pos_en, .zero_delay_input_neg_en,
  .input_loop_fb_src);
`default_nettype wire

// ---- tb/irp_input_rx_cfg_tb.sv ----
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module irp_input_rx_cfg_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] RXA = irp_pkg::RX_CTRL_OFS;
  localparam logic [9:0] FBA = irp_pkg::FB_PATH_OFS;
  logic clk = 0, nrst = 0, ce = 1, reg_wr = 0, reg_rd = 0;
  logic [9:0] reg_addr = 0, fb_div_word = 0, test_div_ratio, fb_div_ratio, a;
  logic [7:0] reg_wdata = 0, reg_rdata, rx = 0, fb = 0;
  logic [5:0] test_div_word = 0;
  logic reg_rvalid, reg_unmapped, test_reference_rx_en, test_div_bypass, fb_div_bypass;
  wire [2:0] pri, sec, osc, zd;
  logic [2:0] input_loop_fb_src;
  int error_cnt = 0, samples_checked = 0, cyc = 0, k;
  logic [15:0] k_list [5] = '{16'h0430, 16'h1c20, 16'h7bcf, 16'hffff, 16'h020b};
  irp_input_rx_cfg u_irp_input_rx_cfg (.clk, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .reg_rvalid, .reg_unmapped, .test_div_word, .fb_div_word,
    .test_reference_rx_en, .primary_reference_diff_en(pri[2]),
    .primary_reference_pos_en(pri[1]), .primary_reference_neg_en(pri[0]),
    .secondary_reference_diff_en(sec[2]), .secondary_reference_pos_en(sec[1]),
    .secondary_reference_neg_en(sec[0]), .oscillator_input_diff_en(osc[2]),
    .oscillator_input_pos_en(osc[1]), .oscillator_input_neg_en(osc[0]),
    .zero_delay_input_diff_en(zd[2]), .zero_delay_input_pos_en(zd[1]),
    .zero_delay_input_neg_en(zd[0]), .test_div_bypass, .fb_div_bypass, .test_div_ratio,
    .fb_div_ratio, .input_loop_fb_src);
  // expected {diff, pos, neg} of one receiver
  function automatic logic [2:0] rxm(logic on, logic d, logic s);
    return {on & d, on & ~d & ~s, on & ~d & s};
  endfunction : rxm
  // a bypass or a word of 0 or 1 both mean divide by one
  function automatic logic [9:0] ratio(logic b, logic [9:0] w);
    return (b || w <= 10'h001) ? 10'h001 : w;
  endfunction : ratio
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic check_outs;
    `CHK("test_rx", rx[7], test_reference_rx_en)
    `CHK("pri", rxm(~rx[2] | rx[3], rx[5], fb[0]), pri)
    `CHK("sec", rxm(~rx[2] | rx[4], rx[6], fb[1]), sec)
    `CHK("osc", rxm(1'b1, rx[0], rx[1]), osc)
    `CHK("zd", rxm(~fb[4] & ~fb[5], fb[2], fb[3]), zd)
    `CHK("byp", fb[7:6], {test_div_bypass, fb_div_bypass})
    `CHK("tdr", ratio(fb[7], 10'(test_div_word)), test_div_ratio)
    `CHK("fdr", ratio(fb[6], fb_div_word), fb_div_ratio)
    `CHK("src", fb[4] ? 3'h1 : fb[5] ? 3'h2 : 3'h4, input_loop_fb_src)
  endtask : check_outs
  // writes are ignored by the model when ce is low, like the block
  task automatic wr(logic [9:0] ad, logic [7:0] d);
    @(negedge clk);
    reg_addr = ad;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
    if (ce && ad == RXA) rx = d;
    else if (ce && ad == FBA) fb = d;
  endtask : wr
  task automatic rd(logic [9:0] ad);
    logic [7:0] e;
    e = ad == RXA ? rx : ad == FBA ? fb : 8'h00;
    @(negedge clk);
    reg_addr = ad;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
    `CHK("rvalid", 1'b1, reg_rvalid)
    `CHK("unmapped", ad != RXA && ad != FBA, reg_unmapped)
    `CHK("rdata", e, reg_rdata)
  endtask : rd
  // clock and hang guard
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test;
    end
  end
  initial begin
    void'($urandom(87757));
    repeat (2) @(negedge clk);
    nrst = 1;
    @(negedge clk);
    check_outs;
    rd(RXA);
    rd(FBA);
    // corners: power-down control, ignored zero-delay bit, all ones
    foreach (k_list[j]) begin
      wr(RXA, k_list[j][15:8]);
      wr(FBA, k_list[j][7:0]);
      @(negedge clk);
      check_outs;
    end
    for (int i = 0; i < 400; i++) begin
      k = $urandom % 8;
      test_div_word = k < 2 ? 6'(k) : 6'($urandom);
      fb_div_word = k < 2 ? 10'(k ^ 1) : 10'($urandom);
      a = k < 3 ? RXA : k < 6 ? FBA : 10'($urandom);
      ce = ($urandom % 8) != 0;
      wr(a, 8'($urandom));
      ce = 1;
      @(negedge clk);
      check_outs;
      if (k >= 6) rd(a);
    end
    // mid-run reset returns both registers to zero
    test_div_word = 0;
    fb_div_word = 0;
    nrst = 0;
    rx = 0;
    fb = 0;
    @(negedge clk);
    check_outs;
    nrst = 1;
    @(negedge clk);
    check_outs;
    finish_test;
  end
endmodule : irp_input_rx_cfg_tb
`default_nettype wire
